// ==== core/tnvm_pkg.sv ====
// Package with constants, states and carrier types of the two-wire byte memory
`default_nettype none
package tnvm_pkg;
   // Array geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 512;
   localparam int PAGE_W = 1;
   localparam int WORD_ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
   // Bit counter for one byte on the wire
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   // Slave address byte fields
   localparam int SA_DIR_BIT = 0;
   localparam int SA_PAGE_BIT = 1;
   localparam int SA_SEL_LO_BIT = 2;
   localparam int SA_SEL_HI_BIT = 3;
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_TYPE_MSB = 7;
   localparam int SEL_W = 2;
   localparam int TYPE_W = 4;
   // Device type code, value is arbitrary
   localparam logic [TYPE_W-1:0] DEV_TYPE_DEFAULT = 4'h5;
   // Timing: core clock and fastest legal serial clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCL_MAX_FREQ_KHZ = 1000;
   localparam int SCL_MIN_PERIOD_NS = 1000000 / SCL_MAX_FREQ_KHZ;
   localparam int SCL_MIN_HALF_CYCLES = (SCL_MIN_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int SCL_MIN_HALF_NEEDED = 4;
   // Buffer between byte receiver and array write port
   localparam int WR_BUF_DEPTH = 2;
   // Idle levels of the synchronised pins
   localparam logic LINE_IDLE = 1'b1;
   localparam logic WP_RST = 1'b0;
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

   // Protocol states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_DEV       = 9'h002,
      ST_ACK_DEV   = 9'h004,
      ST_WORD      = 9'h008,
      ST_ACK_WORD  = 9'h010,
      ST_WRITE     = 9'h020,
      ST_ACK_WRITE = 9'h040,
      ST_READ      = 9'h080,
      ST_ACK_READ  = 9'h100
   } tnvm_state_type;

   // One pending array write
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } tnvm_wr_entry_type;

   // Decoded bus events, each a one-cycle pulse
   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } tnvm_bus_event_type;
endpackage
`default_nettype wire

// ==== core/tnvm_memory.sv ====
// Two-wire slave byte memory: synchronisers, write buffer and protocol engine
//
// Summary of operation
// [RULE1] Array holds 512 byte locations, reached only over the serial bus.
// [RULE2] Word address is 8 bits selecting one of 256 locations.
// [RULE3] One page bit splits the array into two pages, sent with slave address.
// [RULE4] Page bit is the MSB of the 9-bit byte address.
// [RULE5] Respond only when address select bits match the strap pins.
// [RULE6] Write protect high blocks every array change.
// [RULE7] Write protect low allows writes to every address.
// [RULE8] Floating write protect reads low, so array stays writable. No pull-down here; a floating pin is not forced low.
// [RULE9] Data line output changes only on serial clock falling edge.
// [RULE10] Incoming data bits are sampled on serial clock rising edge.
// [RULE11] Data line is open drain: pull low or release, never drive high.
// [RULE12] Each received data byte is committed right after its transfer.
// [RULE13] Writes finish before the next transaction; never busy, no polling.
// [RULE14] Master keeps serial clock at or below 1 MHz.
// [RULE15] Power-on reset brings the interface to a defined idle state.
// [RULE16] Slave byte: bit3 upper strap, bit2 lower strap, bit1 page, bit0 direction.
// [RULE17] Address increments after each data byte, wraps 1FFh to 000h, unlimited burst.
// [RULE18] When protected, data bytes are not acknowledged, address does not advance.
// [RULE19] Reads carry no word address, continue from the latch with slave page bit.
// [RULE20] A start condition anywhere abandons the operation and awaits a slave byte.
`default_nettype none

// Two-stage synchroniser for pins outside the core clock domain
module tnvm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end
   assign sync_o = sync_reg;
endmodule

// Small FIFO with valid/ready on both sides
module tnvm_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
   logic [WIDTH-1:0] store_reg [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic push;
   logic pop;
   initial begin
      if (DEPTH < 2 || WIDTH < 1) begin
         $error("tnvm_fifo: DEPTH must be at least 2 and WIDTH at least 1");
      end
   end

   assign in_ready_o = (count_reg != FULL_CNT);
   assign out_valid_o = (count_reg != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = store_reg[rd_ptr_reg];

   // Entry storage, written on push
   always_ff @(posedge clk_i) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// Top: the serial byte memory as seen behind its pins
module tnvm_memory
   import tnvm_pkg::*;
#(
   parameter logic [tnvm_pkg::TYPE_W-1:0] DEV_TYPE = tnvm_pkg::DEV_TYPE_DEFAULT
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_b_o,
   input wire logic [tnvm_pkg::SEL_W-1:0] device_select_straps_i,
   input wire logic write_protect_i,
   output tnvm_pkg::tnvm_state_type state_o
);
   import tnvm_pkg::*;

   logic rst_meta_reg;
   logic rst_sync_b_reg;
   logic scl_sync;
   logic sda_sync;
   logic wp_sync;
   logic [SEL_W-1:0] sel_sync;
   logic scl_prev_reg;
   logic sda_prev_reg;
   tnvm_bus_event_type ev;
   tnvm_state_type state_reg;
   tnvm_state_type state_next;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] tx_reg;
   logic [CNT_W-1:0] bit_cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic page_reg;
   logic read_dir_reg;
   logic master_ack_reg;
   logic pull_low_reg;
   logic [DATA_W-1:0] mem_reg [0:MEM_DEPTH-1];
   logic byte_done;
   logic dev_hit;
   logic wr_try;
   logic wr_accept;
   logic rd_load;
   logic [DATA_W-1:0] rd_byte;
   tnvm_wr_entry_type wr_in;
   tnvm_wr_entry_type wr_out;
   logic wr_in_ready;
   logic wr_out_valid;
   logic wr_out_ready;

   initial begin
      if (SCL_MIN_HALF_CYCLES < SCL_MIN_HALF_NEEDED) begin
         $error("tnvm_memory: core clock too slow to sample the serial clock");
      end
   end

   // Power-on reset released through two flip-flops
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_b_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_b_reg <= rst_meta_reg;
      end
   end

   // Pin synchronisers; bus lines idle high, straps and protect idle low
   tnvm_sync #(.WIDTH(2), .RESET_VAL({LINE_IDLE, LINE_IDLE})) u_sync_bus (
      .clk_i(core_clk_i),
      .rst_b_i(rst_sync_b_reg),
      .async_i({scl_i, sda_i}),
      .sync_o({scl_sync, sda_sync})
   );

   tnvm_sync #(.WIDTH(SEL_W + 1), .RESET_VAL({SEL_RST, WP_RST})) u_sync_cfg (
      .clk_i(core_clk_i),
      .rst_b_i(rst_sync_b_reg),
      .async_i({device_select_straps_i, write_protect_i}),
      .sync_o({sel_sync, wp_sync})
   );

   // Previous line levels for edge and condition detection
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         scl_prev_reg <= LINE_IDLE;
         sda_prev_reg <= LINE_IDLE;
      end else begin
         scl_prev_reg <= scl_sync;
         sda_prev_reg <= sda_sync;
      end
   end

   // Bus events: clock edges, start and stop while clock high
   assign ev.scl_rise = scl_sync && !scl_prev_reg;
   assign ev.scl_fall = !scl_sync && scl_prev_reg;
   assign ev.start = scl_sync && scl_prev_reg && sda_prev_reg && !sda_sync;
   assign ev.stop = scl_sync && scl_prev_reg && !sda_prev_reg && sda_sync;

   // Decoded conditions of the current byte
   assign byte_done = ev.scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
   assign dev_hit = (shift_reg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE)
                  && (shift_reg[SA_SEL_HI_BIT] == sel_sync[1])  // [RULE5] [RULE16]
                  && (shift_reg[SA_SEL_LO_BIT] == sel_sync[0]);  // [RULE5] [RULE16]
   // Protect level is the synchronised pin; no pull-down here, so a floating pin is not forced low
   assign wr_try = (state_reg == ST_WRITE) && byte_done && !wp_sync;  // [RULE6] [RULE7] [RULE8]
   assign wr_accept = wr_try && wr_in_ready;
   assign rd_load = ev.scl_fall
                  && (((state_reg == ST_ACK_DEV) && read_dir_reg)
                      || ((state_reg == ST_ACK_READ) && master_ack_reg));
   assign rd_byte = mem_reg[addr_reg];  // [RULE19]

   // Next protocol state
   always_comb begin
      state_next = state_reg;
      if (ev.start) begin
         state_next = ST_DEV;  // [RULE20]
      end else if (ev.stop) begin
         state_next = ST_IDLE;
      end else if (ev.scl_fall) begin
         unique case (state_reg)
            ST_DEV: state_next = !byte_done ? ST_DEV : (dev_hit ? ST_ACK_DEV : ST_IDLE);  // [RULE5]
            ST_ACK_DEV: state_next = read_dir_reg ? ST_READ : ST_WORD;  // [RULE19]
            ST_WORD: state_next = byte_done ? ST_ACK_WORD : ST_WORD;
            ST_ACK_WORD: state_next = ST_WRITE;
            ST_WRITE: state_next = !byte_done ? ST_WRITE : (wr_accept ? ST_ACK_WRITE : ST_IDLE);  // [RULE18]
            ST_ACK_WRITE: state_next = ST_WRITE;
            ST_READ: state_next = byte_done ? ST_ACK_READ : ST_READ;
            ST_ACK_READ: state_next = master_ack_reg ? ST_READ : ST_IDLE;
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // State register, idle after power-on reset
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         state_reg <= ST_IDLE;  // [RULE15]
      end else begin
         state_reg <= state_next;
      end
   end

   // Receive shifter and bit counter, sampled on the rising clock edge
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         shift_reg <= '0;
         bit_cnt_reg <= '0;
      end else if (ev.start) begin
         bit_cnt_reg <= '0;
      end else if (ev.scl_rise && bit_cnt_reg != BITS_PER_BYTE
                   && (state_reg == ST_DEV || state_reg == ST_WORD
                       || state_reg == ST_WRITE || state_reg == ST_READ)) begin
         shift_reg <= {shift_reg[DATA_W-2:0], sda_sync};  // [RULE10]
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end else if (ev.scl_fall && (state_reg == ST_ACK_DEV || state_reg == ST_ACK_WORD
                   || state_reg == ST_ACK_WRITE || state_reg == ST_ACK_READ)) begin
         bit_cnt_reg <= '0;
      end
   end

   // Direction and page captured from a matching slave byte
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         page_reg <= 1'b0;
         read_dir_reg <= 1'b0;
      end else if (state_reg == ST_DEV && byte_done && dev_hit) begin
         page_reg <= shift_reg[SA_PAGE_BIT];  // [RULE3] [RULE16]
         read_dir_reg <= shift_reg[SA_DIR_BIT];  // [RULE16]
      end
   end

   // Address latch: load, page update on reads, increment with wrap
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         addr_reg <= ADDR_RST;
      end else if (state_reg == ST_DEV && byte_done && dev_hit && shift_reg[SA_DIR_BIT]) begin
         addr_reg[ADDR_W-1] <= shift_reg[SA_PAGE_BIT];  // [RULE19]
      end else if (state_reg == ST_WORD && byte_done) begin
         addr_reg <= {page_reg, shift_reg[WORD_ADDR_W-1:0]};  // [RULE2] [RULE4]
      end else if (wr_accept || (state_reg == ST_READ && byte_done)) begin
         addr_reg <= addr_reg + 1'b1;  // [RULE17] [RULE18]
      end
   end

   // Master acknowledge after a read byte, sampled on the rising edge
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         master_ack_reg <= 1'b0;
      end else if (state_reg == ST_ACK_READ && ev.scl_rise) begin
         master_ack_reg <= !sda_sync;
      end
   end

   // Transmit shifter loaded from the array and moved on falling edges
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         tx_reg <= '0;
      end else if (rd_load) begin
         tx_reg <= rd_byte;
      end else if (state_reg == ST_READ && ev.scl_fall && bit_cnt_reg != BITS_PER_BYTE) begin
         tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
      end
   end

   // Open-drain pull-down, changed only on the falling clock edge
   always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
      if (!rst_sync_b_reg) begin
         pull_low_reg <= 1'b0;
      end else if (ev.start || ev.stop) begin
         pull_low_reg <= 1'b0;
      end else if (ev.scl_fall) begin  // [RULE9]
         unique case (state_reg)
            ST_DEV: pull_low_reg <= byte_done && dev_hit;
            ST_WORD: pull_low_reg <= byte_done;
            ST_WRITE: pull_low_reg <= wr_accept;  // [RULE18]
            ST_READ: pull_low_reg <= !byte_done && !tx_reg[DATA_W-2];
            ST_ACK_DEV, ST_ACK_READ: pull_low_reg <= rd_load && !rd_byte[DATA_W-1];
            default: pull_low_reg <= 1'b0;
         endcase
      end
   end

   // Pin only ever pulls low; enable is active low
   assign sda_o = 1'b0;  // [RULE11]
   assign sda_oe_b_o = !pull_low_reg;  // [RULE11]
   assign state_o = state_reg;

   // Write buffer between receiver and array; full buffer withholds acknowledge
   assign wr_in = '{addr: addr_reg, data: shift_reg};
   assign wr_out_ready = !rd_load;

   tnvm_fifo #(.WIDTH($bits(tnvm_wr_entry_type)), .DEPTH(WR_BUF_DEPTH)) u_wr_buf (
      .clk_i(core_clk_i),
      .rst_b_i(rst_sync_b_reg),
      .in_valid_i(wr_try),
      .in_ready_o(wr_in_ready),
      .in_data_i(wr_in),
      .out_valid_o(wr_out_valid),
      .out_ready_i(wr_out_ready),
      .out_data_o(wr_out)
   );

   // Array commit within core cycles of the byte, long before the next transfer
   always_ff @(posedge core_clk_i) begin
      if (wr_out_valid && wr_out_ready) begin
         mem_reg[wr_out.addr] <= wr_out.data;  // [RULE1] [RULE12] [RULE13]
      end
   end
endmodule
`default_nettype wire

// ==== bench/tnvm_bus_master.sv ====
// Two-wire bus master model that drives the serial clock and data toward the memory
`default_nettype none
module tnvm_bus_master (
   input wire logic clk_i,
   input wire logic sda_wire_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int hp = 2; // Falling edges per quarter bit: 2 gives a 400 ns bit, 5 a 1000 ns bit
   // Bus idles with both lines released high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Quarter bit time, so every change lands on a core clock falling edge
   task automatic qtr();
      repeat (hp) @(negedge clk_i);
   endtask
   // Start, also used as a repeated start from a low clock
   task automatic start();
      sda_o = 1'b1;
      qtr();
      scl_o = 1'b1;
      qtr();
      sda_o = 1'b0;
      qtr();
      scl_o = 1'b0;
      qtr();
   endtask
   // Stop, then the clock stands still high
   task automatic stop();
      sda_o = 1'b0;
      qtr();
      scl_o = 1'b1;
      qtr();
      sda_o = 1'b1;
      qtr();
      qtr();
   endtask
   // One bit: data set while clock low and held through the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      qtr();
      scl_o = 1'b1;
      qtr();
      r = sda_wire_i;
      qtr();
      scl_o = 1'b0;
      qtr();
   endtask
   // Byte out MSB first, then the ninth clock reads the acknowledge
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Byte in MSB first, then acknowledge to continue or not to end
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~more, r);
   endtask
endmodule
`default_nettype wire

// ==== bench/tnvm_memory_sva.sv ====
// Concurrent checks on the pins of the two-wire byte memory
`default_nettype none
module tnvm_memory_sva
   import tnvm_pkg::*;
#(
   parameter logic [tnvm_pkg::TYPE_W-1:0] DEV_TYPE = tnvm_pkg::DEV_TYPE_DEFAULT
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_b_o,
   input wire logic [tnvm_pkg::SEL_W-1:0] device_select_straps_i,
   input wire logic write_protect_i,
   input wire tnvm_pkg::tnvm_state_type state_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_q;
   logic sda_q;
   logic [3:0] fall_cnt;
   logic [7:0] rx_sh;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Previous pin levels
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end
   // Cycles since the serial clock pin fell, saturating
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fall_cnt <= 4'hf;
      end else if (scl_q && !scl_i) begin
         fall_cnt <= 4'h0;
      end else if (fall_cnt != 4'hf) begin
         fall_cnt <= fall_cnt + 4'h1;
      end
   end
   // Bits seen on the wire at each serial clock rise
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_sh <= 8'h00;
      end else if (!scl_q && scl_i) begin
         rx_sh <= {rx_sh[6:0], sda_i};
      end
   end
   a_oe_on_fall: assert property ($changed(sda_oe_b_o) |-> fall_cnt inside {[4'h1:4'h6]})
      else $error("SDA drive changed away from a serial clock fall");
   a_drive_low_only: assert property (!sda_oe_b_o |-> sda_o == 1'b0)
      else $error("SDA driven high");
   a_idle_quiet: assert property (state_o == ST_IDLE |-> sda_oe_b_o)
      else $error("SDA pulled while idle");
   a_state_onehot: assert property ($onehot(state_o))
      else $error("State not one-hot");
   a_reset_idle: assert property ($rose(rst_b_i) |-> state_o == ST_IDLE && sda_oe_b_o)
      else $error("Not idle after reset");
   a_ack_straps: assert property ($fell(sda_oe_b_o) && state_o inside {ST_DEV, ST_ACK_DEV} |->
      rx_sh[3:2] == device_select_straps_i && rx_sh[7:4] == DEV_TYPE)
      else $error("Slave byte acked without a match");
   a_wp_no_ack: assert property ($fell(sda_oe_b_o) && state_o inside {ST_WRITE, ST_ACK_WRITE} |->
      !write_protect_i)
      else $error("Data byte acked while protected");
   a_start_restarts: assert property (scl_q && scl_i && sda_q && !sda_i |-> ##[1:6] state_o == ST_DEV)
      else $error("Start did not restart");
   a_stop_idles: assert property (scl_q && scl_i && !sda_q && sda_i |-> ##[1:6] state_o == ST_IDLE)
      else $error("Stop did not go idle");
   c_slave_ack: cover property ($fell(sda_oe_b_o) && state_o inside {ST_DEV, ST_ACK_DEV});
   c_read: cover property (state_o == ST_READ);
   c_wp_refused: cover property (write_protect_i && state_o == ST_WRITE ##[1:80] state_o == ST_IDLE);
endmodule
bind tnvm_memory tnvm_memory_sva #(.DEV_TYPE(DEV_TYPE)) u_sva (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_b_o(sda_oe_b_o), .device_select_straps_i(device_select_straps_i),
   .write_protect_i(write_protect_i), .state_o(state_o));
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench for the two-wire byte memory: bus transactions with expected values
`default_nettype none
module tb;
   import tnvm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic wp = 1'b0;
   logic [1:0] straps = 2'h2;
   logic scl;
   logic sda_m;
   logic sda_o;
   logic sda_oe_b;
   tnvm_state_type state;
   wire logic sda_wire;
   int n_errors = 0;
   int cmp_count = 0;
   // Wired-AND data line with pull-up
   assign sda_wire = sda_m & (sda_oe_b | sda_o);
   // Core clock, 50 ns period
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   tnvm_memory dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
      .sda_oe_b_o(sda_oe_b), .device_select_straps_i(straps), .write_protect_i(wp), .state_o(state));
   tnvm_bus_master mst (.clk_i(core_clk), .sda_wire_i(sda_wire), .scl_o(scl), .sda_o(sda_m));
   // Verdict and end of run
   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Slave byte with type and current straps
   function automatic logic [7:0] sab(input logic pg, input logic rd);
      return {DEV_TYPE_DEFAULT, straps, pg, rd};
   endfunction
   // Send a byte and check the acknowledge
   task automatic tx(input logic [7:0] b, input logic exp_ack);
      logic a;
      mst.wr_byte(b, a);
      chk(9'(a), 9'(exp_ack));
   endtask
   // Read a byte and check its value
   task automatic rx(input logic [7:0] exp, input logic more);
      logic [7:0] d;
      mst.rd_byte(more, d);
      chk(9'(d), 9'(exp));
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge core_clk);
      chk(state, ST_IDLE);
      chk(9'(sda_oe_b), 9'h001);
      rst_b = 1'b1;
      repeat (10) @(negedge core_clk);
      chk(state, ST_IDLE);
      // Only the strap value in bits 3..2 is acknowledged
      for (int i = 0; i < 4; i++) begin
         mst.start();
         tx({DEV_TYPE_DEFAULT, i[1:0], 2'h0}, i[1:0] == straps);
         mst.stop();
      end
      straps = 2'h1;
      mst.start();
      tx({~DEV_TYPE_DEFAULT, straps, 2'h0}, 1'b0);
      mst.stop();
      // Burst on the upper page crosses the top address
      mst.start();
      tx(sab(1'b1, 1'b0), 1'b1);
      tx(8'hfe, 1'b1);
      tx(8'ha5, 1'b1);
      tx(8'h5a, 1'b1);
      tx(8'h3c, 1'b1);
      mst.stop();
      mst.start();
      tx(sab(1'b1, 1'b0), 1'b1);
      tx(8'hfe, 1'b1);
      mst.stop();
      mst.start();
      tx(sab(1'b1, 1'b1), 1'b1);
      rx(8'ha5, 1'b1);
      rx(8'h5a, 1'b1);
      rx(8'h3c, 1'b0);
      mst.stop();
      // Reset while the slave acknowledge is pulled: line released, array kept
      mst.start();
      tx(sab(1'b1, 1'b0), 1'b1);
      rst_b = 1'b0;
      repeat (6) @(negedge core_clk);
      chk(state, ST_IDLE);
      chk(9'(sda_oe_b), 9'h001);
      rst_b = 1'b1;
      repeat (10) @(negedge core_clk);
      mst.stop();
      mst.start();
      tx(sab(1'b0, 1'b1), 1'b1);
      rx(8'h3c, 1'b0);
      mst.stop();
      // Protected write is refused and leaves the address in place
      mst.start();
      tx(sab(1'b0, 1'b0), 1'b1);
      tx(8'h10, 1'b1);
      tx(8'h11, 1'b1);
      tx(8'h22, 1'b1);
      mst.stop();
      wp = 1'b1;
      mst.start();
      tx(sab(1'b0, 1'b0), 1'b1);
      tx(8'h10, 1'b1);
      tx(8'h77, 1'b0);
      mst.stop();
      wp = 1'b0;
      mst.start();
      tx(sab(1'b0, 1'b1), 1'b1);
      rx(8'h11, 1'b1);
      rx(8'h22, 1'b0);
      mst.stop();
      // Master at its 1 MHz limit; a repeated start after the word address makes a read
      mst.hp = 5;
      mst.start();
      tx(sab(1'b0, 1'b0), 1'b1);
      tx(8'h11, 1'b1);
      mst.start();
      tx(sab(1'b0, 1'b1), 1'b1);
      rx(8'h22, 1'b0);
      mst.stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
